/* File: design/pcl_pkg.sv */
// Constants of the configuration register bank: addresses, fields,
// reset values and timing. Assumes an 8-bit register file reached by
// 16-bit serial frames.
`default_nettype none
package pcl_pkg;
  // ****************************************************************
  // Register addresses and frame layout.
  // ****************************************************************
  localparam logic [6:0] ADDR_HWC    = 7'h0F;
  localparam logic [6:0] ADDR_PIN    = 7'h17;
  localparam logic [6:0] ADDR_DUTY   = 7'h18;
  localparam logic [6:0] ADDR_FREQ   = 7'h1C;
  localparam int         FRAME_BITS  = 16;
  localparam int         ADDR_BITS   = 8;
  localparam int         WR_FLAG     = 7;
  // ****************************************************************
  // Field positions and reset values.
  // ****************************************************************
  localparam int         HWC_OSC_LSB = 5;
  localparam int         HWC_PEAK    = 4;
  localparam int         HWC_SS_LSB  = 2;
  localparam int         HWC_RSV     = 1;
  localparam int         HWC_LOCK    = 0;
  localparam logic [7:0] HWC_RST     = 8'h40;
  localparam logic [7:0] HWC_WMASK   = 8'hFD;
  localparam logic [2:0] PIN_RST     = 3'h0;
  localparam logic [7:0] DUTY_RST    = 8'h00;
  localparam logic [1:0] FREQ_RST    = 2'h0;
  // ****************************************************************
  // Pin function codes.
  // ****************************************************************
  localparam logic [2:0] PIN_CYCLIC  = 3'h3;
  localparam logic [2:0] PIN_OFF     = 3'h4;
  localparam logic [2:0] PIN_WAKE    = 3'h5;
  localparam logic [2:0] PIN_PWM_LS  = 3'h6;
  localparam logic [2:0] PIN_PWM_HS  = 3'h7;
  // ****************************************************************
  // Timing.
  // ****************************************************************
  localparam int         CLK_HZ      = 125_000_000;
  localparam int         PWM_STEPS   = 255;
  localparam int         PWM_HZ_0    = 100;
  localparam int         PWM_HZ_1    = 200;
  localparam int         PWM_HZ_2    = 325;
  localparam int         PWM_HZ_3    = 400;
  localparam int         WAKE_FILT_US = 16;
  localparam int         WAKE_FILT_CYC = WAKE_FILT_US * (CLK_HZ / 1_000_000);
endpackage
`default_nettype wire

/* File: design/pcl_regs.sv */
// Configuration register bank with serial frame slave and PWM pin driver.
// Assumes frames of 16 bits, LSB first, sampled on serial clock rising
// edge; soft reset and restart are one-cycle pulses from the mode logic.
//
// Summary of operation
// - Control register at 0x0F, power-up 0x40, kept over restart and soft reset.
// - Bits 7:5 select pump oscillator 1.8 to 2.4 MHz; upper codes reserved.
// - Bit 4 selects low or high regulator peak current threshold.
// - Bits 3:2 select spread spectrum off or 15.625/31.25/62.5 kHz.
// - Reserved bits ignore writes and read as zero.
// - Lock level 1 blocks all writes to the control register; pin, duty and frequency stay writable.
// - Lock level 1 takes effect only when chip select rises.
// - Once active, lock level 1 stays until power-on reset.
// - Soft reset keeps the lock bit and, locked or not, the whole control register.
// - Pin register at 0x17, reset zero; codes 0-2 fail output, 3 cyclic, 4 off.
// - Code 5 wake input with 16 us filter, 6 PWM low side, 7 PWM high side.
// - A wake-configured pin is a default wake source in fail-safe mode.
// - Restart or soft reset loads a pin code given by the pin function.
// - Duty register at 0x18, cleared by power-on and soft reset, kept on restart.
// - Duty 0 means off, 255 means on, otherwise on for N/255.
// - A new duty takes effect at the start of the next period.
// - Frequency register at 0x1C; bits 1:0 select 100/200/325/400 Hz.
// - A new frequency takes effect after the current period.
// - Lock level 0 blocks writes to the pin field.
// - Cyclic sense runs once assigned and a nonzero on-time is set.
`timescale 1ns/1ns
`default_nettype none
module pcl_regs #(
  parameter int P_CLK_HZ = pcl_pkg::CLK_HZ
) (
  input  wire logic       i_mclk,
  input  wire logic       i_rst_b,
  input  wire logic       i_sclk,
  input  wire logic       i_chip_select_n,
  input  wire logic       i_sdi,
  input  wire logic       i_soft_reset,
  input  wire logic       i_restart,
  input  wire logic       i_cfg_lock0,
  input  wire logic [2:0] i_pin_restart_code,
  input  wire logic       i_timer_on_nonzero,
  input  wire logic       i_pin_level,
  output logic            o_sdo,
  output logic            o_sdo_oe,
  output logic [2:0]      o_pump_osc_freq_sel,
  output logic            o_regulator_peak_threshold_sel,
  output logic [1:0]      o_spread_spectrum_rate,
  output logic            o_cfg_lock1,
  output logic [2:0]      o_pin_function,
  output logic            o_fail_output_sel,
  output logic            o_cyclic_sense_run,
  output logic            o_wake_input_level,
  output logic            o_wake_failsafe_src,
  output logic            o_pwm_low_side_on,
  output logic            o_pwm_high_side_on
);
  // ****************************************************************
  // Elaboration check and helpers.
  // ****************************************************************
  if (P_CLK_HZ < pcl_pkg::PWM_HZ_3 * pcl_pkg::PWM_STEPS * 2) begin : g_bad_clk
    $error("Clock too slow for the PWM step counter.");
  end

  // Number of clock cycles in one of the 255 steps of a PWM period.
  function automatic logic [23:0] step_len(input logic [1:0] sel);
    int hz;
    hz = (sel == 2'h0) ? pcl_pkg::PWM_HZ_0 : (sel == 2'h1) ? pcl_pkg::PWM_HZ_1 :
         (sel == 2'h2) ? pcl_pkg::PWM_HZ_2 : pcl_pkg::PWM_HZ_3;
    return 24'(P_CLK_HZ / (hz * pcl_pkg::PWM_STEPS));
  endfunction

  // ****************************************************************
  // Reset release and input synchronisers.
  // ****************************************************************
  logic       rst_s1;
  logic       rst_n;
  logic [3:0] sync1;
  logic [3:0] sync2;
  logic       sclk_prev;
  logic       cs_prev;

  // Reset is asserted at once and released through two flip-flops.
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rst_s1 <= 1'b0;
      rst_n  <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n  <= rst_s1;
    end
  end

  // Pins from outside pass two flip-flops; edges use the second stage.
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      sync1     <= 4'h2;
      sync2     <= 4'h2;
      sclk_prev <= 1'b0;
      cs_prev   <= 1'b1;
    end else begin
      sync1     <= {i_pin_level, i_sdi, i_chip_select_n, i_sclk};
      sync2     <= sync1;
      sclk_prev <= sync2[0];
      cs_prev   <= sync2[1];
    end
  end

  // One-cycle strobes from the synchronised serial clock and chip select.
  wire sclk_rise = sync2[0] & ~sclk_prev;
  wire sclk_fall = ~sync2[0] & sclk_prev;
  wire cs_fall   = ~sync2[1] & cs_prev;
  wire cs_rise   = sync2[1] & ~cs_prev;
  wire in_frame  = ~sync2[1];

  // ****************************************************************
  // Serial frame shifter.
  // ****************************************************************
  logic [15:0] rx;
  logic [4:0]  bit_cnt;
  logic [7:0]  tx;
  logic [7:0]  hwc;
  logic [2:0]  pin;
  logic [7:0]  duty;
  logic [1:0]  freq;

  // Read selection, write strobe and fields of a completed frame.
  wire [6:0] rx_addr = rx[15:9];
  wire [7:0] rd_data = (rx_addr == pcl_pkg::ADDR_HWC)  ? (hwc & pcl_pkg::HWC_WMASK) :
                       (rx_addr == pcl_pkg::ADDR_PIN)  ? {5'h00, pin} :
                       (rx_addr == pcl_pkg::ADDR_DUTY) ? duty :
                       (rx_addr == pcl_pkg::ADDR_FREQ) ? {6'h00, freq} : 8'h00;
  wire       addr_done = sclk_rise & (bit_cnt == 5'(pcl_pkg::ADDR_BITS - 1));
  wire       commit    = cs_rise & (bit_cnt == 5'(pcl_pkg::FRAME_BITS))
                         & rx[pcl_pkg::WR_FLAG];
  wire [6:0] wr_addr   = rx[6:0];
  wire [7:0] wr_data   = rx[15:8];

  // Bits arrive LSB first; the data byte answers the addressed register.
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      rx       <= 16'h0000;
      bit_cnt  <= 5'h00;
      tx       <= 8'h00;
      o_sdo    <= 1'b0;
      o_sdo_oe <= 1'b0;
    end else begin
      o_sdo_oe <= in_frame;
      if (cs_fall) begin
        bit_cnt <= 5'h00;
        tx      <= 8'h00;
        o_sdo   <= 1'b0;
      end else if (in_frame && sclk_rise) begin
        rx      <= {sync2[2], rx[15:1]};
        bit_cnt <= (bit_cnt == 5'h1F) ? bit_cnt : bit_cnt + 5'h01;
        if (addr_done) begin
          tx <= rd_data;
        end
      end else if (in_frame && sclk_fall) begin
        o_sdo <= (bit_cnt >= 5'(pcl_pkg::ADDR_BITS)) ? tx[0] : 1'b0;
        tx    <= (bit_cnt >= 5'(pcl_pkg::ADDR_BITS)) ? {1'b0, tx[7:1]} : tx;
      end
    end
  end

  // ****************************************************************
  // Configuration registers.
  // ****************************************************************
  // Write strobes per register; control and pin strobes gated by the two lock levels.
  wire lock1    = hwc[pcl_pkg::HWC_LOCK];
  wire wr_hwc   = commit & (wr_addr == pcl_pkg::ADDR_HWC) & ~lock1;
  wire wr_pin   = commit & (wr_addr == pcl_pkg::ADDR_PIN) & ~i_cfg_lock0;
  wire wr_duty  = commit & (wr_addr == pcl_pkg::ADDR_DUTY);
  wire wr_freq  = commit & (wr_addr == pcl_pkg::ADDR_FREQ);
  wire any_rst  = i_soft_reset | i_restart;

  // Control register: only power-on reset restores it; a lock freezes it.
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      hwc <= pcl_pkg::HWC_RST;
    end else if (!any_rst && wr_hwc) begin
      hwc <= wr_data & pcl_pkg::HWC_WMASK;
    end
  end

  // Pin field: resets load the code chosen by the current pin function.
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      pin <= pcl_pkg::PIN_RST;
    end else if (any_rst) begin
      pin <= i_pin_restart_code;
    end else if (wr_pin) begin
      pin <= wr_data[2:0];
    end
  end

  // Duty and frequency: soft reset clears, restart keeps.
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      duty <= pcl_pkg::DUTY_RST;
      freq <= pcl_pkg::FREQ_RST;
    end else if (i_soft_reset) begin
      duty <= pcl_pkg::DUTY_RST;
      freq <= pcl_pkg::FREQ_RST;
    end else if (!i_restart) begin
      duty <= wr_duty ? wr_data : duty;
      freq <= wr_freq ? wr_data[1:0] : freq;
    end
  end

  // Control fields leave straight from the stored register.
  assign o_pump_osc_freq_sel            = hwc[7:pcl_pkg::HWC_OSC_LSB];
  assign o_regulator_peak_threshold_sel = hwc[pcl_pkg::HWC_PEAK];
  assign o_spread_spectrum_rate         = hwc[3:pcl_pkg::HWC_SS_LSB];
  assign o_cfg_lock1                    = hwc[pcl_pkg::HWC_LOCK];
  assign o_pin_function                 = pin;

  // ****************************************************************
  // PWM generator and wake filter.
  // ****************************************************************
  logic [23:0] step_cnt;
  logic [7:0]  phase;
  logic [7:0]  duty_act;
  logic [1:0]  freq_act;
  logic        pwm_on;
  logic [11:0] filt_cnt;

  // A step ends after its cycle count; a period ends after the last step.
  wire step_end     = (step_cnt == step_len(freq_act) - 24'h1);
  wire period_start = step_end & (phase == 8'(pcl_pkg::PWM_STEPS - 1));
  wire pin_s        = sync2[3];

  // Period of 255 steps; duty and rate are latched only at its start.
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      step_cnt <= 24'h000000;
      phase    <= 8'h00;
      duty_act <= 8'h00;
      freq_act <= 2'h0;
      pwm_on   <= 1'b0;
    end else begin
      step_cnt <= step_end ? 24'h000000 : step_cnt + 24'h000001;
      phase    <= period_start ? 8'h00 : (step_end ? phase + 8'h01 : phase);
      duty_act <= period_start ? duty : duty_act;
      freq_act <= period_start ? freq : freq_act;
      pwm_on   <= (phase < duty_act);
    end
  end

  // Pin drivers and the static wake filter.
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      o_pwm_low_side_on   <= 1'b0;
      o_pwm_high_side_on  <= 1'b0;
      o_fail_output_sel   <= 1'b1;
      o_cyclic_sense_run  <= 1'b0;
      o_wake_failsafe_src <= 1'b0;
      o_wake_input_level  <= 1'b0;
      filt_cnt            <= 12'h000;
    end else begin
      o_pwm_low_side_on   <= (pin == pcl_pkg::PIN_PWM_LS) & pwm_on;
      o_pwm_high_side_on  <= (pin == pcl_pkg::PIN_PWM_HS) & pwm_on;
      o_fail_output_sel   <= (pin < pcl_pkg::PIN_CYCLIC);
      o_cyclic_sense_run  <= (pin == pcl_pkg::PIN_CYCLIC) & i_timer_on_nonzero;
      o_wake_failsafe_src <= (pin == pcl_pkg::PIN_WAKE);
      if (pin != pcl_pkg::PIN_WAKE || pin_s == o_wake_input_level) begin
        filt_cnt <= 12'h000;
      end else if (filt_cnt == 12'(pcl_pkg::WAKE_FILT_CYC - 1)) begin
        filt_cnt           <= 12'h000;
        o_wake_input_level <= pin_s;
      end else begin
        filt_cnt <= filt_cnt + 12'h001;
      end
    end
  end

  // ****************************************************************
  // Assertions.
  // ****************************************************************
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!rst_n);

  AST_RSV_ZERO: assert property ((rx_addr == pcl_pkg::ADDR_HWC) |-> !rd_data[1])
    else $error("Reserved bit reads as one.");
  AST_LOCK_HOLD: assert property (lock1 |=> lock1)
    else $error("Lock level 1 was cleared.");
  AST_LOCK_BLOCK: assert property (lock1 |=> $stable(hwc))
    else $error("Locked control register changed.");
  AST_LOCK_FRAME: assert property ($rose(lock1) |-> $past(cs_rise))
    else $error("Lock took effect inside a frame.");
  AST_LOCK0_BLOCK: assert property (i_cfg_lock0 && !any_rst |=> $stable(pin))
    else $error("Pin field changed under lock level 0.");
  AST_SOFT_KEEP: assert property (i_soft_reset |=> $stable(hwc))
    else $error("Soft reset changed the control register.");
  AST_RESTART_PIN: assert property (any_rst |=> pin == $past(i_pin_restart_code))
    else $error("Restart pin code not loaded.");
  AST_SOFT_DUTY: assert property (i_soft_reset |=> duty == 8'h00)
    else $error("Soft reset did not clear duty.");
  AST_DUTY_ZERO: assert property (duty_act == 8'h00 ##1 duty_act == 8'h00 |=> !pwm_on)
    else $error("Duty zero drives the switch on.");
  AST_DUTY_FULL: assert property (duty_act == 8'hFF ##1 duty_act == 8'hFF |=> pwm_on)
    else $error("Full duty drives the switch off.");
  AST_DUTY_LATCH: assert property (!period_start |=> $stable(duty_act))
    else $error("Duty changed inside a period.");
  AST_FREQ_LATCH: assert property (!period_start |=> $stable(freq_act))
    else $error("Rate changed inside a period.");

  COV_WRITE_LOCK: cover property (wr_hwc && wr_data[0]);
  COV_PWM_HS: cover property (o_pwm_high_side_on);
  COV_PERIOD: cover property (period_start && duty != duty_act);
  COV_SOFT_LOCKED: cover property (i_soft_reset && lock1);
endmodule
`default_nettype wire

/* File: verification/pcl_spi_master.sv */
// Serial controller model that frames 16-bit commands for the register bank.
// Assumes a 125 MHz system clock; the serial clock runs at 64 ns per bit.
`timescale 1ns/1ns
`default_nettype none
module pcl_spi_master (
  input  wire logic i_mclk,
  input  wire logic i_sdo,
  output logic      o_sclk,
  output logic      o_chip_select_n,
  output logic      o_sdi
);
  // Idle link: serial clock still and low, no device selected.
  initial begin
    o_sclk          = 1'b0;
    o_chip_select_n = 1'b1;
    o_sdi           = 1'b0;
  end

  // Shifts nb bits LSB first; read data is taken at the end of each high phase.
  task automatic xfer(input logic [15:0] fr, input int nb, output logic [7:0] rd);
    rd = 8'h00;
    @(posedge i_mclk);
    o_chip_select_n <= 1'b0;
    for (int b = 0; b < nb; b++) begin
      o_sdi <= fr[b];
      repeat (4) @(posedge i_mclk);
      o_sclk <= 1'b1;
      repeat (4) @(posedge i_mclk);
      if (b >= 8) begin
        rd[b-8] = i_sdo;
      end
      o_sclk <= 1'b0;
    end
    repeat (4) @(posedge i_mclk);
    o_chip_select_n <= 1'b1;
    o_sdi           <= ~fr[nb-1];  // A released line shows the inverse of its last bit.
    repeat (8) @(posedge i_mclk);
  endtask
endmodule
`default_nettype wire

/* File: verification/pcl_regs_test.sv */
// Self-checking bench for the configuration register bank.
// Assumes the serial controller model drives the link and PWM is shortened.
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, gt) begin \
  compares++; \
  if ((gt) !== (ex)) begin \
    err_total++; \
    $display("[FAIL] %s expected %0h seen %0h", nm, ex, gt); \
  end \
end
module pcl_regs_test;
  localparam int CLK_HZ_SIM = 510_000;
  logic       i_mclk, i_rst_b, i_soft_reset, i_restart, i_cfg_lock0;
  logic       i_timer_on_nonzero, i_pin_level;
  logic [2:0] i_pin_restart_code;
  wire logic  sclk, cs_n, sdi, o_sdo, o_sdo_oe, o_peak, o_lock1, o_fail;
  wire logic  o_cyc, o_wlev, o_wsrc, o_ls, o_hs;
  wire logic [2:0] o_osc, o_pin;
  wire logic [1:0] o_ss;
  logic [7:0] v;
  logic       oe_hi = 1'b0;
  int         err_total, compares, hs, ls, step;
  int         hz_tab [4] = '{pcl_pkg::PWM_HZ_0, pcl_pkg::PWM_HZ_1,
                             pcl_pkg::PWM_HZ_2, pcl_pkg::PWM_HZ_3};

  pcl_regs #(.P_CLK_HZ(CLK_HZ_SIM)) pcl_regs_i (
    .i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_sclk(sclk), .i_chip_select_n(cs_n),
    .i_sdi(sdi), .i_soft_reset(i_soft_reset), .i_restart(i_restart),
    .i_cfg_lock0(i_cfg_lock0), .i_pin_restart_code(i_pin_restart_code),
    .i_timer_on_nonzero(i_timer_on_nonzero), .i_pin_level(i_pin_level),
    .o_sdo(o_sdo), .o_sdo_oe(o_sdo_oe), .o_pump_osc_freq_sel(o_osc),
    .o_regulator_peak_threshold_sel(o_peak), .o_spread_spectrum_rate(o_ss),
    .o_cfg_lock1(o_lock1), .o_pin_function(o_pin), .o_fail_output_sel(o_fail),
    .o_cyclic_sense_run(o_cyc), .o_wake_input_level(o_wlev),
    .o_wake_failsafe_src(o_wsrc), .o_pwm_low_side_on(o_ls), .o_pwm_high_side_on(o_hs));
  pcl_spi_master pcl_spi_master_i (
    .i_mclk(i_mclk), .i_sdo(o_sdo), .o_sclk(sclk), .o_chip_select_n(cs_n), .o_sdi(sdi));

  // Records whether the data output was ever enabled inside an open frame.
  always @(posedge i_mclk) begin
    if (!cs_n && o_sdo_oe) begin
      oe_hi <= 1'b1;
    end
  end

  // Free-running system clock of 8 ns.
  initial begin
    i_mclk = 1'b0;
    forever #4 i_mclk = ~i_mclk;
  end

  // Register write and checked read over the serial link.
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] rd;
    pcl_spi_master_i.xfer({d, 1'b1, a}, 16, rd);
  endtask
  task automatic rchk(input logic [6:0] a, input logic [7:0] ex, input string nm);
    logic [7:0] rd;
    pcl_spi_master_i.xfer({8'h00, 1'b0, a}, 16, rd);
    `CHK(nm, ex, rd)
  endtask
  // Waits for the output to settle, then counts on cycles over n cycles.
  task automatic pwm_chk(input int w, input int n, input int ex_hs, input int ex_ls);
    hs = 0;
    ls = 0;
    repeat (w) @(posedge i_mclk);
    repeat (n) begin
      @(posedge i_mclk);
      hs += int'(o_hs === 1'b1);
      ls += int'(o_ls === 1'b1);
    end
    `CHK("high side on count", ex_hs, hs)
    `CHK("low side on count", ex_ls, ls)
  endtask
  // One-cycle soft reset (sr high) or restart pulse with a pin code.
  task automatic pulse(input logic sr, input logic [2:0] code);
    @(posedge i_mclk);
    i_pin_restart_code <= code;
    i_soft_reset       <= sr;
    i_restart          <= ~sr;
    @(posedge i_mclk);
    i_soft_reset <= 1'b0;
    i_restart    <= 1'b0;
    repeat (4) @(posedge i_mclk);
  endtask
  task automatic final_report;
    $display("Comparisons %0d, mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Cuts a hung run short.
  initial begin
    repeat (100000) @(posedge i_mclk);
    `CHK("run time limit", 1'b0, 1'b1)
    final_report;
  end

  // ****************************************************************
  // Main sequence.
  // ****************************************************************
  initial begin
    {i_rst_b, i_soft_reset, i_restart, i_cfg_lock0, i_timer_on_nonzero, i_pin_level} = '0;
    i_pin_restart_code = 3'h0;
    err_total          = 0;
    compares           = 0;
    repeat (6) @(posedge i_mclk);
    i_rst_b <= 1'b1;
    repeat (8) @(posedge i_mclk);
    `CHK("osc sel at reset", 3'h2, o_osc)
    `CHK("fail output at reset", 1'b1, o_fail)
    `CHK("data enable idle", 1'b0, o_sdo_oe)
    rchk(pcl_pkg::ADDR_HWC, 8'h40, "control reset");
    rchk(pcl_pkg::ADDR_PIN, 8'h00, "pin reset");
    rchk(pcl_pkg::ADDR_DUTY, 8'h00, "duty reset");
    rchk(pcl_pkg::ADDR_FREQ, 8'h00, "freq reset");
    wr(7'h20, 8'hFF);
    rchk(7'h20, 8'h00, "unmapped read");
    for (int i = 0; i < 4; i++) begin
      v = {i[2:0], i[0], i[1:0], 2'b10};
      wr(pcl_pkg::ADDR_HWC, v);
      rchk(pcl_pkg::ADDR_HWC, v & 8'hFD, "control readback");
      `CHK("osc sel", i[2:0], o_osc)
      `CHK("peak sel", i[0], o_peak)
      `CHK("spread rate", i[1:0], o_ss)
    end
    wr(pcl_pkg::ADDR_FREQ, 8'hFF);
    rchk(pcl_pkg::ADDR_FREQ, 8'h03, "freq readback");
    i_timer_on_nonzero <= 1'b1;
    for (int c = 0; c < 8; c++) begin
      wr(pcl_pkg::ADDR_PIN, {5'h1F, c[2:0]});
      rchk(pcl_pkg::ADDR_PIN, {5'h00, c[2:0]}, "pin readback");
      `CHK("fail output", c < 3, o_fail)
      `CHK("cyclic sense", c == 3, o_cyc)
      `CHK("wake source", c == 5, o_wsrc)
      `CHK("pwm at zero duty", 2'b00, ({o_hs, o_ls}))
      `CHK("pin function", c[2:0], o_pin)
    end
    i_cfg_lock0 <= 1'b1;
    wr(pcl_pkg::ADDR_PIN, 8'h05);
    rchk(pcl_pkg::ADDR_PIN, 8'h07, "pin under level 0 lock");
    i_cfg_lock0 <= 1'b0;
    wr(pcl_pkg::ADDR_PIN, {5'h00, pcl_pkg::PIN_WAKE});
    i_pin_level <= 1'b1;
    repeat (1990) @(posedge i_mclk);
    `CHK("wake level early", 1'b0, o_wlev)
    repeat (40) @(posedge i_mclk);
    `CHK("wake level filtered", 1'b1, o_wlev)
    wr(pcl_pkg::ADDR_DUTY, 8'h80);
    wr(pcl_pkg::ADDR_PIN, {5'h00, pcl_pkg::PIN_PWM_HS});
    for (int f = 0; f < 4; f++) begin
      wr(pcl_pkg::ADDR_FREQ, {6'h00, f[1:0]});
      step = CLK_HZ_SIM / (hz_tab[f] * 255);
      pwm_chk(10300, 255 * step, 128 * step, 0);
    end
    wr(pcl_pkg::ADDR_DUTY, 8'hFF);
    pwm_chk(2600, 1275, 1275, 0);
    wr(pcl_pkg::ADDR_PIN, {5'h00, pcl_pkg::PIN_PWM_LS});
    wr(pcl_pkg::ADDR_DUTY, 8'h40);
    pwm_chk(2600, 1275, 0, 320);
    wr(pcl_pkg::ADDR_DUTY, 8'h00);
    pwm_chk(2600, 1275, 0, 0);
    pcl_spi_master_i.xfer({8'h55, 1'b1, pcl_pkg::ADDR_DUTY}, 15, v);
    rchk(pcl_pkg::ADDR_DUTY, 8'h00, "short frame dropped");
    wr(pcl_pkg::ADDR_HWC, 8'h21);
    rchk(pcl_pkg::ADDR_HWC, 8'h21, "lock frame applied");
    `CHK("lock flag", 1'b1, o_lock1)
    wr(pcl_pkg::ADDR_HWC, 8'h40);
    rchk(pcl_pkg::ADDR_HWC, 8'h21, "locked control");
    wr(pcl_pkg::ADDR_PIN, 8'h04);
    rchk(pcl_pkg::ADDR_PIN, 8'h04, "pin under level 1 lock");
    wr(pcl_pkg::ADDR_DUTY, 8'h33);
    wr(pcl_pkg::ADDR_FREQ, 8'h02);
    pulse(1'b1, pcl_pkg::PIN_WAKE);
    rchk(pcl_pkg::ADDR_HWC, 8'h21, "control after soft reset");
    rchk(pcl_pkg::ADDR_PIN, 8'h05, "pin after soft reset");
    rchk(pcl_pkg::ADDR_DUTY, 8'h00, "duty after soft reset");
    rchk(pcl_pkg::ADDR_FREQ, 8'h00, "freq after soft reset");
    wr(pcl_pkg::ADDR_DUTY, 8'h33);
    pulse(1'b0, pcl_pkg::PIN_CYCLIC);
    rchk(pcl_pkg::ADDR_DUTY, 8'h33, "duty after restart");
    rchk(pcl_pkg::ADDR_PIN, 8'h03, "pin after restart");
    rchk(pcl_pkg::ADDR_HWC, 8'h21, "control after restart");
    `CHK("cyclic sense after restart", 1'b1, o_cyc)
    i_timer_on_nonzero <= 1'b0;
    repeat (3) @(posedge i_mclk);
    `CHK("cyclic sense without on-time", 1'b0, o_cyc)
    `CHK("data enable in frame", 1'b1, oe_hi)
    i_rst_b <= 1'b0;
    repeat (6) @(posedge i_mclk);
    i_rst_b <= 1'b1;
    repeat (8) @(posedge i_mclk);
    `CHK("lock after power-on reset", 1'b0, o_lock1)
    rchk(pcl_pkg::ADDR_HWC, 8'h40, "control after power-on reset");
    rchk(pcl_pkg::ADDR_PIN, 8'h00, "pin after power-on reset");
    final_report;
  end
endmodule
`default_nettype wire
